// ---- rtl/mrd_pkg.sv ----
// constants and carrier types for the mapper register decoder
`default_nettype none
package mrd_pkg;
  localparam int          NUM_TRIB      = 21;
  localparam int          CNT_W         = 16;
  localparam int          ADDR_W        = 9;
  localparam int          DATA_W        = 8;
  // global region, low part
  localparam logic [8:0]  ADR_GLOBAL_CONFIGURATION = 9'h000;
  localparam logic [8:0]  ADR_TADD_0    = 9'h001;
  localparam logic [8:0]  ADR_TADD_1    = 9'h002;
  localparam logic [8:0]  ADR_TADD_2    = 9'h003;
  localparam logic [8:0]  ADR_TRACE_RST = 9'h004;
  localparam logic [8:0]  ADR_CHIP_IDENTIFICATION   = 9'h00a;
  localparam logic [8:0]  ADR_INTERRUPT_CONFIGURATION  = 9'h00b;
  localparam logic [8:0]  ADR_GLOBAL_INTERRUPT_SOURCE = 9'h00c;
  localparam logic [8:0]  ADR_TRIB_ID_0 = 9'h00d;
  localparam logic [8:0]  ADR_TRIB_ID_1 = 9'h00e;
  localparam logic [8:0]  ADR_TRIB_ID_2 = 9'h00f;
  // tributary region and high global region
  localparam logic [8:0]  ADR_TRIB_LO   = 9'h010;
  localparam logic [8:0]  ADR_TRIB_HI   = 9'h15f;
  localparam logic [8:0]  ADR_HIGH_GLOB = 9'h160;
  localparam logic [8:0]  ADR_TS_FIRST  = 9'h161;
  localparam logic [8:0]  ADR_TS_LAST   = 9'h175;
  localparam logic [4:0]  TRIB_SEL_MIN  = 5'h01;
  localparam logic [4:0]  TRIB_SEL_MAX  = 5'h15;
  // local offsets inside a tributary window
  localparam logic [3:0]  LOC_INT_0     = 4'h0;
  localparam logic [3:0]  LOC_INT_1     = 4'h1;
  localparam logic [3:0]  LOC_STA_0     = 4'h2;
  localparam logic [3:0]  LOC_STA_1     = 4'h3;
  localparam logic [3:0]  LOC_MASK_0    = 4'h4;
  localparam logic [3:0]  LOC_MASK_1    = 4'h5;
  localparam logic [3:0]  LOC_PAR_0     = 4'h6;
  localparam logic [3:0]  LOC_PAR_1     = 4'h7;
  localparam logic [3:0]  LOC_REM_0     = 4'h8;
  localparam logic [3:0]  LOC_REM_1     = 4'h9;
  localparam logic [3:0]  LOC_ERDI      = 4'ha;
  localparam logic [3:0]  LOC_POH       = 4'hb;
  localparam logic [3:0]  LOC_EXP_TRACE = 4'hc;
  localparam logic [3:0]  LOC_ERR_INS   = 4'hd;
  localparam logic [3:0]  LOC_SIG_LABEL = 4'he;
  localparam logic [3:0]  LOC_TX_TRACE  = 4'hf;
  // field positions and reset values
  localparam int          BIT_REM_OVF   = 4;
  localparam int          BIT_STM_MODE  = 0;
  localparam logic [7:0]  GLOBAL_CONFIGURATION_RST = 8'h10;
  localparam logic [7:0]  GLOBAL_CONFIGURATION_WM  = 8'h7e;
  localparam logic [23:0] TADD_RST      = 24'h000000;
  localparam logic [23:0] TADD_WM       = 24'h1fffff;
  localparam logic [7:0]  INTERRUPT_CONFIGURATION_RST  = 8'h00;
  localparam logic [7:0]  TS_CONF_RST   = 8'h00;
  localparam logic [7:0]  CHIP_IDENTIFICATION_VAL   = 8'h5a; // arbitrary value
  // byte clock timing
  localparam int          REF_CLK_KHZ   = 200000;
  localparam int          BYTE_CLK_KHZ  = 6480;
  localparam int          BYTE_DIV      = REF_CLK_KHZ / BYTE_CLK_KHZ;

  typedef struct packed {
    logic [8:0] addr;
    logic [7:0] data;
  } mrd_access_t;

  typedef struct packed {
    logic [15:0] interrupt_mask;
    logic [7:0]  expected_trace;
    logic [7:0]  error_insert;
    logic [7:0]  signal_label;
    logic [7:0]  transmit_trace;
  } mrd_trib_cfg_t;
endpackage
`default_nettype wire

// ---- rtl/mrd_counter_snap.sv ----
// one tributary performance counter with its capture buffer
`default_nettype none
module mrd_counter_snap
  import mrd_pkg::*;
#(
  parameter int W = CNT_W
) (
  input  wire logic         ref_clk,  // system clock
  input  wire logic         rst,      // async reset
  input  wire logic         byte_en,  // byte clock enable
  input  wire logic         inc,      // count one error
  input  wire logic         snap,     // capture request
  output logic [W-1:0]      buf_val,  // captured count
  output logic              overflow  // wrap pulse
);
  logic [W-1:0] count;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      count    <= '0;
      overflow <= 1'b0;
    end else begin
      overflow <= 1'b0;
      if (byte_en && inc) begin
        count    <= count + 1'b1;
        overflow <= &count;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      buf_val <= '0;
    end else if (snap) begin
      buf_val <= count;
    end
  end
endmodule
`default_nettype wire

// ---- rtl/mrd_register_decode.sv ----
// register decoder, access attributes and counter capture for the e1 mapper
`default_nettype none
module mrd_register_decode
  import mrd_pkg::*;
#(
  parameter int NTRIB = NUM_TRIB,
  parameter int CW    = CNT_W,
  parameter int BDIV  = BYTE_DIV
) (
  input  wire logic                     ref_clk,        // system clock
  input  wire logic                     rst,            // async reset, active high
  input  wire logic [ADDR_W-1:0]        addr_pin,       // host address
  input  wire logic [DATA_W-1:0]        data_in,        // host data in
  output logic      [DATA_W-1:0]        data_out,       // read data
  output logic                          data_oe,        // data pin enable
  input  wire logic                     cs_n,           // chip select
  input  wire logic                     rd_n,           // read strobe
  input  wire logic                     wr_n,           // write strobe
  input  wire logic                     stm_mode_pin,   // speed strap
  input  wire logic [NTRIB-1:0][15:0]   trib_event,     // interrupt set pulses
  input  wire logic [NTRIB-1:0][15:0]   trib_status,    // alarm state
  input  wire logic [NTRIB-1:0][7:0]    trib_erdi,      // enhanced rdi state
  input  wire logic [NTRIB-1:0][7:0]    trib_poh,       // path overhead state
  input  wire logic [NTRIB-1:0]         parity_err_inc, // parity error pulse
  input  wire logic [NTRIB-1:0]         remote_err_inc, // remote error pulse
  output logic      [7:0]               global_configuration,      // global configuration
  output logic      [23:0]              transmit_add_select,      // transmit add select
  output logic      [7:0]               interrupt_configuration,       // interrupt configuration
  output logic                          trace_mem_rst,  // trace memory reset pulse
  output logic      [NTRIB-1:0][7:0]    ts_conf,        // port time slots
  output mrd_trib_cfg_t [NTRIB-1:0]     trib_cfg        // per-tributary settings
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [ADDR_W-1:0] addr_s1, addr_s2;
  logic [DATA_W-1:0] data_s1, data_s2;
  logic [2:0]        ctl_s1, ctl_s2, ctl_s3;
  logic              stm_s1, stm_s2;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      addr_s1 <= '0;
      addr_s2 <= '0;
      data_s1 <= '0;
      data_s2 <= '0;
      ctl_s1  <= 3'h7;
      ctl_s2  <= 3'h7;
      ctl_s3  <= 3'h7;
      stm_s1  <= 1'b0;
      stm_s2  <= 1'b0;
    end else begin
      addr_s1 <= addr_pin;
      addr_s2 <= addr_s1;
      data_s1 <= data_in;
      data_s2 <= data_s1;
      ctl_s1  <= {cs_n, rd_n, wr_n};
      ctl_s2  <= ctl_s1;
      ctl_s3  <= ctl_s2;
      stm_s1  <= stm_mode_pin;
      stm_s2  <= stm_s1;
    end
  end

  logic cs_s2, rd_s2, wr_s2, cs_s3, rd_s3, wr_s3;
  assign {cs_s2, rd_s2, wr_s2} = ctl_s2;
  assign {cs_s3, rd_s3, wr_s3} = ctl_s3;

  ////////////////////////////////////////////////////////////////////////////
  // strobe detection; a write is taken as its strobe ends
  mrd_access_t wr_hold;
  logic        wr_take, rd_take;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wr_hold <= '0;
    end else if (!wr_s2 && !cs_s2) begin
      wr_hold <= '{addr: addr_s2, data: data_s2};
    end
  end

  assign wr_take = wr_s2 && !wr_s3 && !cs_s3;
  assign rd_take = !rd_s2 && rd_s3 && !cs_s2;

  ////////////////////////////////////////////////////////////////////////////
  // address decode
  logic [8:0] wa, ra;
  logic       w_trib, r_trib;
  logic [4:0] w_sel, r_sel;
  logic [3:0] w_loc, r_loc;

  assign wa    = wr_hold.addr;
  assign ra    = addr_s2;
  assign w_sel = wa[8:4];
  assign w_loc = wa[3:0];
  assign r_sel = ra[8:4];
  assign r_loc = ra[3:0];
  assign w_trib = (wa >= ADR_TRIB_LO) && (wa <= ADR_TRIB_HI) && (w_sel >= TRIB_SEL_MIN) && (w_sel <= TRIB_SEL_MAX);
  assign r_trib = (ra >= ADR_TRIB_LO) && (ra <= ADR_TRIB_HI) && (r_sel >= TRIB_SEL_MIN) && (r_sel <= TRIB_SEL_MAX);

  ////////////////////////////////////////////////////////////////////////////
  // byte clock enable
  logic [7:0] div_cnt;
  logic       byte_en;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      div_cnt <= '0;
      byte_en <= 1'b0;
    end else if (div_cnt == 8'(BDIV - 1)) begin
      div_cnt <= '0;
      byte_en <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 8'h01;
      byte_en <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // global registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      global_configuration <= GLOBAL_CONFIGURATION_RST;
    end else begin
      global_configuration[BIT_STM_MODE] <= stm_s2;
      if (wr_take && wa == ADR_GLOBAL_CONFIGURATION) begin
        global_configuration[7:1] <= wr_hold.data[7:1] & GLOBAL_CONFIGURATION_WM[7:1];
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      transmit_add_select <= TADD_RST;
      interrupt_configuration  <= INTERRUPT_CONFIGURATION_RST;
    end else if (wr_take) begin
      if (wa == ADR_TADD_0) begin
        transmit_add_select[7:0] <= wr_hold.data & TADD_WM[7:0];
      end else if (wa == ADR_TADD_1) begin
        transmit_add_select[15:8] <= wr_hold.data & TADD_WM[15:8];
      end else if (wa == ADR_TADD_2) begin
        transmit_add_select[23:16] <= wr_hold.data & TADD_WM[23:16];
      end else if (wa == ADR_INTERRUPT_CONFIGURATION) begin
        interrupt_configuration <= wr_hold.data;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      trace_mem_rst <= 1'b0;
    end else begin
      trace_mem_rst <= wr_take && (wa == ADR_TRACE_RST);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-port and per-tributary registers
  logic [NTRIB-1:0][15:0]   int_flags;
  logic [NTRIB-1:0][CW-1:0] par_buf, rem_buf;
  logic [NTRIB-1:0]         rem_ovf;
  logic [NTRIB-1:0]         trib_pend;

  genvar t;
  generate
    for (t = 0; t < NTRIB; t++) begin : g_trib
      logic w_hit, r_hit, snap_par, snap_rem;
      logic [15:0] clr, set;

      assign w_hit = wr_take && w_trib && (w_sel == 5'(t + 1));
      assign r_hit = rd_take && r_trib && (r_sel == 5'(t + 1));

      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          ts_conf[t] <= TS_CONF_RST;
        end else if (wr_take && wa == 9'(ADR_TS_FIRST + 9'(t))) begin
          ts_conf[t] <= wr_hold.data;
        end
      end

      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          trib_cfg[t] <= '0;
        end else if (w_hit) begin
          case (w_loc)
            LOC_MASK_0:    trib_cfg[t].interrupt_mask[7:0]  <= wr_hold.data;
            LOC_MASK_1:    trib_cfg[t].interrupt_mask[15:8] <= wr_hold.data;
            LOC_EXP_TRACE: trib_cfg[t].expected_trace       <= wr_hold.data;
            LOC_ERR_INS:   trib_cfg[t].error_insert         <= wr_hold.data;
            LOC_SIG_LABEL: trib_cfg[t].signal_label         <= wr_hold.data;
            LOC_TX_TRACE:  trib_cfg[t].transmit_trace       <= wr_hold.data;
            default: ;
          endcase
        end
      end

      // event sets win over a clearing read
      assign clr = {{8{r_hit && r_loc == LOC_INT_1}}, {8{r_hit && r_loc == LOC_INT_0}}};
      assign set = trib_event[t] | (16'(rem_ovf[t]) << BIT_REM_OVF);

      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          int_flags[t] <= '0;
        end else begin
          int_flags[t] <= (int_flags[t] & ~clr) | set;
        end
      end

      assign trib_pend[t] = |(int_flags[t] & trib_cfg[t].interrupt_mask);

      assign snap_par = w_hit && (w_loc == LOC_PAR_0 || w_loc == LOC_PAR_1);
      assign snap_rem = w_hit && (w_loc == LOC_REM_0 || w_loc == LOC_REM_1);

      mrd_counter_snap #(.W(CW)) u_par (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .byte_en  (byte_en),
        .inc      (parity_err_inc[t]),
        .snap     (snap_par),
        .buf_val  (par_buf[t]),
        .overflow ()
      );

      mrd_counter_snap #(.W(CW)) u_rem (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .byte_en  (byte_en),
        .inc      (remote_err_inc[t]),
        .snap     (snap_rem),
        .buf_val  (rem_buf[t]),
        .overflow (rem_ovf[t])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // interrupt identification
  logic [23:0] trib_id;
  logic [7:0]  global_interrupt_source;

  assign trib_id   = 24'(trib_pend);
  assign global_interrupt_source = {5'h00, |trib_id[20:14], |trib_id[13:8], |trib_id[7:0]};

  ////////////////////////////////////////////////////////////////////////////
  // read multiplexer
  logic [7:0]  next_rdata;
  logic [15:0] par_w, rem_w;
  logic [4:0]  ri;

  assign ri    = r_sel - 5'h01;
  assign par_w = 16'(par_buf[ri]);
  assign rem_w = 16'(rem_buf[ri]);

  always_comb begin
    next_rdata = 8'h00;
    if (r_trib) begin
      case (r_loc)
        LOC_INT_0:     next_rdata = int_flags[ri][7:0];
        LOC_INT_1:     next_rdata = int_flags[ri][15:8];
        LOC_STA_0:     next_rdata = trib_status[ri][7:0];
        LOC_STA_1:     next_rdata = trib_status[ri][15:8];
        LOC_MASK_0:    next_rdata = trib_cfg[ri].interrupt_mask[7:0];
        LOC_MASK_1:    next_rdata = trib_cfg[ri].interrupt_mask[15:8];
        LOC_PAR_0:     next_rdata = par_w[7:0];
        LOC_PAR_1:     next_rdata = par_w[15:8];
        LOC_REM_0:     next_rdata = rem_w[7:0];
        LOC_REM_1:     next_rdata = rem_w[15:8];
        LOC_ERDI:      next_rdata = trib_erdi[ri];
        LOC_POH:       next_rdata = trib_poh[ri];
        LOC_EXP_TRACE: next_rdata = trib_cfg[ri].expected_trace;
        LOC_ERR_INS:   next_rdata = trib_cfg[ri].error_insert;
        LOC_SIG_LABEL: next_rdata = trib_cfg[ri].signal_label;
        LOC_TX_TRACE:  next_rdata = trib_cfg[ri].transmit_trace;
        default:       next_rdata = 8'h00;
      endcase
    end else if (ra == ADR_GLOBAL_CONFIGURATION) begin
      next_rdata = global_configuration;
    end else if (ra == ADR_TADD_0) begin
      next_rdata = transmit_add_select[7:0];
    end else if (ra == ADR_TADD_1) begin
      next_rdata = transmit_add_select[15:8];
    end else if (ra == ADR_TADD_2) begin
      next_rdata = transmit_add_select[23:16];
    end else if (ra == ADR_TRACE_RST) begin
      next_rdata = 8'h00;
    end else if (ra == ADR_CHIP_IDENTIFICATION) begin
      next_rdata = CHIP_IDENTIFICATION_VAL;
    end else if (ra == ADR_INTERRUPT_CONFIGURATION) begin
      next_rdata = interrupt_configuration;
    end else if (ra == ADR_GLOBAL_INTERRUPT_SOURCE) begin
      next_rdata = global_interrupt_source;
    end else if (ra == ADR_TRIB_ID_0) begin
      next_rdata = trib_id[7:0];
    end else if (ra == ADR_TRIB_ID_1) begin
      next_rdata = trib_id[15:8];
    end else if (ra == ADR_TRIB_ID_2) begin
      next_rdata = trib_id[23:16];
    end else if (ra >= ADR_TS_FIRST && ra <= ADR_TS_LAST) begin
      next_rdata = ts_conf[5'(ra - ADR_TS_FIRST)];
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      data_out <= '0;
    end else if (rd_take) begin
      data_out <= next_rdata;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      data_oe <= 1'b0;
    end else begin
      data_oe <= !cs_s2 && !rd_s2 && !rd_s3;
    end
  end
endmodule
`default_nettype wire

// ---- testbench/mrd_checker_sva.sv ----
// pin-level assertions for the register decoder
`default_nettype none
module mrd_checker_sva
  import mrd_pkg::*;
#(
  parameter int NTRIB = NUM_TRIB
) (
  input wire logic                  ref_clk,       // clock
  input wire logic                  rst,           // async reset
  input wire logic [ADDR_W-1:0]     addr_pin,      // host address
  input wire logic [DATA_W-1:0]     data_out,      // read data
  input wire logic                  data_oe,       // data enable
  input wire logic                  cs_n,          // chip select
  input wire logic                  rd_n,          // read strobe
  input wire logic                  wr_n,          // write strobe
  input wire logic [7:0]            global_configuration,     // global config
  input wire logic [23:0]           transmit_add_select,     // add select
  input wire logic [7:0]            interrupt_configuration,      // interrupt config
  input wire logic                  trace_mem_rst, // trace reset pulse
  input wire logic [NTRIB-1:0][7:0] ts_conf        // time slots
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  // a read held on one address long enough to load data_out
  sequence rd_at(logic [8:0] a);
    (!rd_n && !cs_n && addr_pin == a) [*6];
  endsequence

  oe_rise_a: assert property ($fell(rd_n) && !cs_n |-> ##[3:5] data_oe)
    else $error("data enable missing after read strobe");
  oe_source_a: assert property (data_oe |-> !$past(rd_n, 3) || !$past(rd_n, 4))
    else $error("data enable without read strobe");
  reset_val_a: assert property ($fell(rst) |-> global_configuration[7:1] == GLOBAL_CONFIGURATION_RST[7:1]
    && transmit_add_select == TADD_RST && interrupt_configuration == INTERRUPT_CONFIGURATION_RST && !data_oe)
    else $error("register not at default after reset");
  trace_pulse_a: assert property (trace_mem_rst |-> wr_n && addr_pin == ADR_TRACE_RST ##1 !trace_mem_rst)
    else $error("trace reset pulse wrong");
  cfg_quiet_a: assert property (wr_n [*6] |=> $stable({global_configuration[7:1], transmit_add_select, interrupt_configuration, ts_conf}))
    else $error("configuration changed without write");
  hold_data_a: assert property (rd_n [*4] |=> $stable(data_out))
    else $error("read data changed without read");
  reserved_zero_a: assert property (rd_at(ADR_HIGH_GLOB) |-> data_out == 8'h00)
    else $error("reserved location read nonzero");
  chip_identification_a: assert property (rd_at(ADR_CHIP_IDENTIFICATION) |-> data_out == CHIP_IDENTIFICATION_VAL)
    else $error("identification read wrong");
  wo_zero_a: assert property (rd_at(ADR_TRACE_RST) |-> data_out == 8'h00)
    else $error("write-only location read nonzero");

  cover property (rd_at(ADR_CHIP_IDENTIFICATION));
  cover property ($rose(trace_mem_rst));
  cover property (!$stable(ts_conf));
endmodule
`default_nettype wire

// ---- testbench/mrd_host.sv ----
// host processor model on the asynchronous byte bus
`default_nettype none
module mrd_host
  import mrd_pkg::*;
(
  input  wire logic       ref_clk,  // clock
  input  wire logic [7:0] data_out, // device read data
  input  wire logic       data_oe,  // device drives data
  output logic      [8:0] addr_pin, // address
  output wire logic [7:0] data_in,  // data wire level
  output logic            cs_n,     // chip select
  output logic            rd_n,     // read strobe
  output logic            wr_n      // write strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  int         extra = 0;
  logic [7:0] drv   = 8'h00;

  // wire level from both drivers
  assign data_in = data_oe ? data_out : drv;

  initial begin
    addr_pin = 9'h000;
    cs_n     = 1'b1;
    rd_n     = 1'b1;
    wr_n     = 1'b1;
  end

  // one strobe cycle; extra stretches it for a slow host
  task automatic acc(input bit w, input logic [8:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge ref_clk);
    addr_pin <= a;
    drv      <= d;
    cs_n     <= 1'b0;
    rd_n     <= w;
    wr_n     <= !w;
    repeat (6 + extra) @(posedge ref_clk);
    q = data_out;
    cs_n     <= 1'b1;
    rd_n     <= 1'b1;
    wr_n     <= 1'b1;
    drv      <= ~d;  // released bus driven to the inverted data
    repeat (6 + extra) @(posedge ref_clk);
  endtask
endmodule
`default_nettype wire

// ---- testbench/tb_top.sv ----
// self-checking bench for the register decoder
`default_nettype none
module tb_top
  import mrd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NT = NUM_TRIB;
  logic ref_clk, rst, cs_n, rd_n, wr_n, data_oe, stm_mode_pin, trace_mem_rst;
  logic [8:0]             addr_pin;
  logic [7:0]             data_in, data_out, global_configuration, interrupt_configuration, q;
  logic [23:0]            transmit_add_select;
  logic [NT-1:0][15:0]    trib_event, trib_status;
  logic [NT-1:0][7:0]     trib_erdi, trib_poh, ts_conf;
  logic [NT-1:0]          parity_err_inc, remote_err_inc;
  mrd_trib_cfg_t [NT-1:0] trib_cfg;
  logic [7:0]             mdl [0:511];
  logic [7:0]             wm [0:511];
  int n_errors = 0, samples_checked = 0, seed = 94644;
  int ia [4] = '{12, 13, 'h30, 'h31};
  logic [7:0] ie [4] = '{8'h01, 8'h04, 8'h01, 8'h02};

  mrd_register_decode #(.NTRIB(NT), .CW(4), .BDIV(4)) i_mrd_register_decode (.ref_clk, .rst, .addr_pin,
    .data_in, .data_out, .data_oe, .cs_n, .rd_n, .wr_n, .stm_mode_pin, .trib_event, .trib_status, .trib_erdi,
    .trib_poh, .parity_err_inc, .remote_err_inc, .global_configuration, .transmit_add_select, .interrupt_configuration, .trace_mem_rst,
    .ts_conf, .trib_cfg);
  mrd_host i_mrd_host (.ref_clk, .data_out, .data_oe, .addr_pin, .data_in, .cs_n, .rd_n, .wr_n);

  always #2.5 ref_clk = ~ref_clk;

  task automatic chk(logic [23:0] s, logic [23:0] e);
    samples_checked++;
    if (s !== e) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  // expected read value of one location
  function automatic logic [7:0] exp_rd(int a);
    logic [3:0] o;
    int         t;
    o = a[3:0];
    t = a / 16 - 1;
    if (a >= 'h10 && a < 'h160 && (o == 2 || o == 3)) return trib_status[t][8*(o-2) +: 8];
    if (a >= 'h10 && a < 'h160 && o == 10) return trib_erdi[t];
    if (a >= 'h10 && a < 'h160 && o == 11) return trib_poh[t];
    if (a == 'h00a) return CHIP_IDENTIFICATION_VAL;
    return mdl[a];
  endfunction

  task automatic wr(int a, logic [7:0] d);
    i_mrd_host.acc(1'b1, a[8:0], d, q);
    mdl[a] = (mdl[a] & ~wm[a]) | (d & wm[a]);
  endtask

  task automatic rd(int a);
    i_mrd_host.acc(1'b0, a[8:0], 8'h00, q);
    chk(q, exp_rd(a));
  endtask

  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    repeat (80000) @(posedge ref_clk);
    n_errors++;
    conclude();
  end

  initial begin
    ref_clk = 1'b0;
    rst = 1'b1;
    stm_mode_pin = 1'($random(seed));
    trib_event = '0;
    parity_err_inc = '0;
    remote_err_inc = '0;
    for (int t = 0; t < NT; t++) begin
      trib_status[t] = 16'($random(seed));
      trib_erdi[t] = 8'($random(seed));
      trib_poh[t] = 8'($random(seed));
    end
    for (int a = 0; a < 512; a++) begin
      mdl[a] = 8'h00;
      wm[a] = 8'h00;
    end
    wm[0] = GLOBAL_CONFIGURATION_WM;
    wm[1] = 8'hff;
    wm[2] = 8'hff;
    wm[3] = TADD_WM[23:16];
    wm[11] = 8'hff;
    for (int t = 1; t <= NT; t++) begin
      for (int o = 12; o < 16; o++) wm[16*t+o] = 8'hff;
      wm[16*t+4] = 8'hff;
      wm[16*t+5] = 8'hff;
      wm['h160+t] = 8'hff;
    end
    mdl[0] = {GLOBAL_CONFIGURATION_RST[7:1], stm_mode_pin};
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    ////////////////////////////////////////////////////////////////////////
    for (int a = 0; a < 512; a++) rd(a);
    for (int a = 0; a < 512; a++) wr(a, 8'($random(seed)));
    for (int a = 0; a < 512; a++) rd(a);
    for (int t = 0; t < NT; t++) chk(ts_conf[t], mdl['h161+t]);
    chk(transmit_add_select, {mdl[3], mdl[2], mdl[1]});
    chk(global_configuration, mdl[0]);
    chk(interrupt_configuration, mdl['h00b]);
    chk(trib_cfg[20].interrupt_mask, {mdl['h155], mdl['h154]});
    ////////////////////////////////////////////////////////////////////////
    // counter capture with a slow host
    i_mrd_host.extra = 3;
    @(posedge ref_clk);
    parity_err_inc[0] <= 1'b1;
    remote_err_inc[20] <= 1'b1;
    repeat (40) @(posedge ref_clk);
    parity_err_inc[0] <= 1'b0;
    remote_err_inc[20] <= 1'b0;
    wr('h159, 8'($random(seed)));
    wr('h017, 8'($random(seed)));
    repeat (12) @(posedge ref_clk);
    mdl['h158] = 8'd10;
    mdl['h016] = 8'd10;
    for (int a = 'h158; a < 'h15a; a++) rd(a);
    rd('h017);
    rd('h016);
    @(posedge ref_clk);
    remote_err_inc[20] <= 1'b1;
    repeat (40) @(posedge ref_clk);
    remote_err_inc[20] <= 1'b0;
    wr('h158, 8'h00);
    repeat (12) @(posedge ref_clk);
    mdl['h158] = 8'd4;
    mdl['h150] = 8'h10;
    rd('h158);
    rd('h150);
    mdl['h150] = 8'h00;
    rd('h150);
    i_mrd_host.extra = 0;
    ////////////////////////////////////////////////////////////////////////
    // event flags, identification and clearing
    wr('h034, 8'h01);
    wr('h035, 8'h00);
    @(posedge ref_clk);
    trib_event[2] <= 16'h0201;
    @(posedge ref_clk);
    trib_event[2] <= '0;
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 4; i++) begin
        mdl[ia[i]] = p ? 8'h00 : ie[i];
        rd(ia[i]);
      end
    end
    conclude();
  end
endmodule

bind mrd_register_decode mrd_checker_sva #(.NTRIB(NTRIB)) i_mrd_checker_sva (.ref_clk, .rst, .addr_pin,
  .data_out, .data_oe, .cs_n, .rd_n, .wr_n, .global_configuration, .transmit_add_select, .interrupt_configuration, .trace_mem_rst, .ts_conf);
`default_nettype wire
